// File: design/uart_brg_regs.vh
`ifndef UART_BRG_REGS_VH
`define UART_BRG_REGS_VH

// ----------------------------------------
// Register word indices (word index = byte address / 4)
// ----------------------------------------
`define ADDR_DATA_BUFFER 4'h0
`define ADDR_DIVISOR 4'h1
`define ADDR_CONTROL_TWO 4'h2
`define ADDR_STATUS 4'h3
`define ADDR_W 4

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define SPEED_SELECT_BIT 5
`define SPEED_SELECT_RST 1'h0
`define CTRL_RST 8'h00
`define DIVISOR_RST 8'h00
`define DATA_RST 8'h00
`define STAT_BUSY_BIT 0
`define WORD_SHIFT 2
`define LANE_LOW 0
`define DATA_MSB 7
`define READ_PAD 24'h000000
`define STAT_PAD 31'h00000000
`define BITS_RST 4'h0
`define BITS_LAST 4'h1
`define BITS_STEP 4'h1
`define PRE_RST 6'h00
`define TIMER_RST 8'h00
`define TIMER_END 8'h00

// ----------------------------------------
// Prescale counts: 64 = 4 x 16, 16 = 1 x 16
// ----------------------------------------
`define PRE_LOW_MAX 6'h3F
`define PRE_HIGH_MAX 6'h0F
`define FRAME_BITS 4'hA
`define UNMAPPED_DATA 32'h00000000

`endif

// File: design/rate_timer.v
`timescale 1ns/1ns
`default_nettype none
`include "uart_brg_regs.vh"

module rate_timer (
	input wire clk,
	input wire rst,
	input wire ce,
	input wire speed_select,
	input wire [7:0] divisor_bits,
	output reg tick_q
);

reg [5:0] pre_q;
reg [7:0] cnt_q;
wire [5:0] pre_max;
wire pre_end;

assign pre_max = speed_select ? `PRE_HIGH_MAX : `PRE_LOW_MAX;
assign pre_end = (pre_q >= pre_max);

// ----------------------------------------
// Prescaler and free-running 8-bit timer
// ----------------------------------------
always @(posedge clk) begin
	if (rst) begin
		pre_q <= `PRE_RST;
		cnt_q <= `TIMER_RST;
		tick_q <= 1'b0;
	end else if (ce) begin
		tick_q <= 1'b0;
		if (pre_end) begin
			pre_q <= `PRE_RST;
			if (cnt_q == `TIMER_END) begin
				cnt_q <= divisor_bits;
				tick_q <= 1'b1;
			end else begin
				cnt_q <= cnt_q - 8'h01;
			end
		end else begin
			pre_q <= pre_q + 6'h01;
		end
	end
end

endmodule
`default_nettype wire

// File: design/uart_baud_rate_generator.v
`timescale 1ns/1ns
`default_nettype none
`include "uart_brg_regs.vh"

// Behaviour
// - 8-bit read/write data buffer holds transmit byte
// - 8-bit read/write divisor N, any value 0 to 255
// - Speed select 0: bit rate is clock over 64(N+1)
// - Speed select 1: bit rate is clock over 16(N+1)
// - Dedicated free-running 8-bit timer, period set by divisor and speed
// - Speed select set means high-speed mode, smaller divide factor
// - Speed select is bit 5 of control register two, reset 0
// - Write to buffer while idle starts sending immediately
module uart_baud_rate_generator (
	input wire clk,
	input wire rst,
	input wire ce,
	input wire [3:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	output reg bit_tick,
	output reg tx_start,
	output reg [7:0] tx_byte,
	output reg tx_busy
);

reg [7:0] serial_data_buffer_q;
reg [7:0] serial_data_buffer_d;
reg [7:0] bit_rate_divisor_q;
reg [7:0] bit_rate_divisor_d;
reg [7:0] serial_control_two_q;
reg [7:0] serial_control_two_d;
reg [31:0] readdata_d;
reg waitrequest_d;
reg ack_q;
reg ack_d;
reg tx_state_q;
reg tx_state_d;
reg [3:0] bits_left_q;
reg [3:0] bits_left_d;
reg tx_start_d;
reg [7:0] tx_byte_d;
reg tx_busy_d;
wire tick;
wire speed_select;
wire [3:0] word;
wire access;
wire rd_take;
wire wr_take;
wire wr_buf;

// ----------------------------------------
// Transmit states
// ----------------------------------------
localparam TX_IDLE = 1'b0;
localparam TX_FRAME = 1'b1;

// ----------------------------------------
// Access decode
// ----------------------------------------
assign word = avs_address >> `WORD_SHIFT;
assign access = (avs_read || avs_write) && !ack_q;
assign rd_take = avs_read && !ack_q;
assign wr_take = avs_write && !ack_q && avs_byteenable[`LANE_LOW];
assign wr_buf = wr_take && word == `ADDR_DATA_BUFFER;
assign speed_select = serial_control_two_q[`SPEED_SELECT_BIT];

// ----------------------------------------
// Bit-rate timer
// ----------------------------------------
// divide selection
rate_timer u_timer (
	.clk(clk),
	.rst(rst),
	.ce(ce),
	.speed_select(speed_select),
	.divisor_bits(bit_rate_divisor_q),
	.tick_q(tick)
);

// ----------------------------------------
// Avalon handshake, one wait cycle per access
// ----------------------------------------
always @* begin
	ack_d = access;
	waitrequest_d = !access;
end

// ----------------------------------------
// Register writes
// ----------------------------------------
always @* begin
	serial_data_buffer_d = serial_data_buffer_q;
	bit_rate_divisor_d = bit_rate_divisor_q;
	serial_control_two_d = serial_control_two_q;
	if (wr_take) begin
		case (word)
			`ADDR_DATA_BUFFER: begin
				serial_data_buffer_d = avs_writedata[`DATA_MSB:0];
			end
			`ADDR_DIVISOR: begin
				bit_rate_divisor_d = avs_writedata[`DATA_MSB:0];
			end
			`ADDR_CONTROL_TWO: begin
				serial_control_two_d = avs_writedata[`DATA_MSB:0];
			end
			default: begin
			end
		endcase
	end
end

// ----------------------------------------
// Register readback
// ----------------------------------------
always @* begin
	readdata_d = avs_readdata;
	if (rd_take) begin
		case (word)
			`ADDR_DATA_BUFFER: begin
				readdata_d = {`READ_PAD, serial_data_buffer_q};
			end
			`ADDR_DIVISOR: begin
				readdata_d = {`READ_PAD, bit_rate_divisor_q};
			end
			`ADDR_CONTROL_TWO: begin
				readdata_d = {`READ_PAD, serial_control_two_q};
			end
			`ADDR_STATUS: begin
				readdata_d = {`STAT_PAD, tx_busy};
			end
			default: begin
				readdata_d = `UNMAPPED_DATA;
			end
		endcase
	end
end

// ----------------------------------------
// Bus-side registers
// ----------------------------------------
always @(posedge clk) begin
	if (rst) begin
		ack_q <= 1'b0;
		avs_waitrequest <= 1'b1;
		avs_readdata <= `UNMAPPED_DATA;
		serial_data_buffer_q <= `DATA_RST;
		bit_rate_divisor_q <= `DIVISOR_RST;
		serial_control_two_q <= `CTRL_RST;
	end else if (ce) begin
		ack_q <= ack_d;
		avs_waitrequest <= waitrequest_d;
		avs_readdata <= readdata_d;
		serial_data_buffer_q <= serial_data_buffer_d;
		bit_rate_divisor_q <= bit_rate_divisor_d;
		serial_control_two_q <= serial_control_two_d;
	end
end

// ----------------------------------------
// Transmit hand-off and frame timing
// ----------------------------------------
// idle write starts at once
always @* begin
	tx_state_d = tx_state_q;
	bits_left_d = bits_left_q;
	tx_start_d = 1'b0;
	tx_byte_d = tx_byte;
	case (tx_state_q)
		TX_IDLE: begin
			if (wr_buf) begin
				tx_state_d = TX_FRAME;
				tx_start_d = 1'b1;
				tx_byte_d = avs_writedata[`DATA_MSB:0];
				bits_left_d = `FRAME_BITS;
			end
		end
		TX_FRAME: begin
			// Frame length counted in ticks
			if (tick) begin
				bits_left_d = bits_left_q - `BITS_STEP;
				if (bits_left_q == `BITS_LAST) begin
					tx_state_d = TX_IDLE;
				end
			end
		end
		default: begin
			tx_state_d = TX_IDLE;
		end
	endcase
	tx_busy_d = (tx_state_d == TX_FRAME);
end

// ----------------------------------------
// Transmit registers
// ----------------------------------------
always @(posedge clk) begin
	if (rst) begin
		tx_state_q <= TX_IDLE;
		bits_left_q <= `BITS_RST;
		bit_tick <= 1'b0;
		tx_start <= 1'b0;
		tx_byte <= `DATA_RST;
		tx_busy <= 1'b0;
	end else if (ce) begin
		tx_state_q <= tx_state_d;
		bits_left_q <= bits_left_d;
		bit_tick <= tick;
		tx_start <= tx_start_d;
		tx_byte <= tx_byte_d;
		tx_busy <= tx_busy_d;
	end
end

endmodule
`default_nettype wire

// File: bench/brg_props.sv
`timescale 1ns/1ns
`default_nettype none
module brg_props (
	input wire logic clk,
	input wire logic rst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic bit_tick,
	input wire logic tx_start,
	input wire logic [7:0] tx_byte,
	input wire logic tx_busy
);
	// ----
	// Checks
	// ----
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("wait low twice");
	chk_req_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("no answer");
	chk_read_upper: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
		else $error("upper bits set");
	chk_tick_gap: assert property (bit_tick |=> !bit_tick [*4])
		else $error("tick too soon");
	chk_start_pulse: assert property (tx_start |=> !tx_start)
		else $error("start too long");
	chk_start_busy: assert property (tx_start |-> tx_busy)
		else $error("start not busy");
	chk_start_idle: assert property (tx_start |-> !$past(tx_busy))
		else $error("start while busy");
	chk_byte_hold: assert property (tx_busy && !tx_start |-> $stable(tx_byte))
		else $error("byte changed");
	cover property (bit_tick);
	cover property (tx_start);
	cover property (avs_read && !avs_waitrequest);
endmodule
`default_nettype wire

// File: bench/serial_sink.sv
`timescale 1ns/1ns
`default_nettype none
module serial_sink (
	input wire logic clk,
	input wire logic tx_start,
	input wire logic [7:0] tx_byte,
	output logic [7:0] got
);
	always @(posedge clk) begin
		if (tx_start) got <= tx_byte;
	end
endmodule
`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic clk = 1'h0, rst = 1'h1, ce = 1'h1, avs_read = 1'h0, avs_write = 1'h0;
	logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
	logic [31:0] avs_writedata = 32'h0, rd;
	wire [31:0] avs_readdata;
	wire avs_waitrequest, bit_tick, tx_start, tx_busy;
	wire [7:0] tx_byte, got;
	int miscompares = 0, checked = 0;
	uart_baud_rate_generator u_uart_baud_rate_generator (.clk, .rst, .ce, .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
		.avs_waitrequest, .bit_tick, .tx_start, .tx_byte, .tx_busy);
	serial_sink u_serial_sink (.clk, .tx_start, .tx_byte, .got);
	always #5 clk = ~clk;
	task automatic final_report;
		if (miscompares == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			miscompares++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
		int i;
		i = 0;
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_byteenable <= be;
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge clk);
			i++;
		end while (avs_waitrequest !== 1'h0 && i < 50);
		rd = avs_readdata;
		avs_write <= 1'h0;
		avs_read <= 1'h0;
		@(posedge clk);
		if (i >= 50) begin
			miscompares++;
			final_report();
		end
	endtask
	task automatic t_send;
		int c;
		bus(1'h0, 4'h0, 8'h0, 4'hF);
		chk(rd, 32'h0);
		bus(1'h1, 4'h0, 8'hA5, 4'h1);
		chk({tx_busy, got}, 32'h1A5);
		bus(1'h0, 4'hC, 8'h0, 4'hF);
		chk(rd, 32'h1);
		bus(1'h1, 4'h0, 8'h3C, 4'h1);
		bus(1'h0, 4'h0, 8'h0, 4'hF);
		chk(rd, 32'h3C);
		chk({24'h0, got}, 32'hA5);
		c = 0;
		while (tx_busy !== 1'h0 && c < 2000) begin
			@(posedge clk);
			c++;
		end
		if (c >= 2000) begin
			miscompares++;
			final_report();
		end
		bus(1'h0, 4'hC, 8'h0, 4'hF);
		chk(rd, 32'h0);
		bus(1'h1, 4'h0, 8'h5A, 4'h1);
		chk({tx_busy, got}, 32'h15A);
	endtask
	task automatic wait_tick(inout int c);
		do begin
			@(posedge clk);
			c++;
		end while (bit_tick !== 1'h1 && c < 20000);
		if (c >= 20000) begin
			miscompares++;
			final_report();
		end
	endtask
	task automatic t_freeze;
		int c;
		bus(1'h1, 4'h4, 8'h00, 4'h1);
		bus(1'h1, 4'h8, 8'h20, 4'h1);
		c = 0;
		wait_tick(c);
		ce <= 1'h0;
		repeat (20) @(posedge clk);
		ce <= 1'h1;
		c = 20;
		wait_tick(c);
		chk(c, 16 + 20);
	endtask
	task automatic t_regs;
		bus(1'h0, 4'h8, 8'h0, 4'hF);
		chk(rd, 32'h0);
		bus(1'h1, 4'h4, 8'hFF, 4'h1);
		bus(1'h1, 4'h4, 8'h00, 4'h0);
		bus(1'h0, 4'h4, 8'h0, 4'hF);
		chk(rd, 32'hFF);
	endtask
	task automatic period(input logic s, input logic [7:0] n);
		int c;
		bus(1'h1, 4'h4, n, 4'h1);
		bus(1'h1, 4'h8, {2'h0, s, 5'h0}, 4'h1);
		bus(1'h0, 4'h8, 8'h0, 4'hF);
		chk(rd, {26'h0, s, 5'h0});
		repeat (2) begin
			c = 0;
			wait_tick(c);
		end
		chk(c, (s ? 16 : 64) * (n + 1));
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		t_send();
		t_regs();
		period(1'h0, 8'h00);
		period(1'h0, 8'h02);
		period(1'h1, 8'h00);
		period(1'h1, 8'hFF);
		t_freeze();
		final_report();
	end
endmodule
bind uart_baud_rate_generator brg_props u_brg_props (.clk, .rst, .avs_read, .avs_write,
	.avs_readdata, .avs_waitrequest, .bit_tick, .tx_start, .tx_byte, .tx_busy);
`default_nettype wire
